/* File: inc/hia_regs.svh */
// Register offsets, field positions and reset values for the interrupt aggregator.
// Assumes a simple word-wide register port driven by the surrounding PCI target logic.
`ifndef HIA_REGS_SVH
`define HIA_REGS_SVH

`define HIA_PCI_CMD_OFS 8'h04
`define HIA_PCI_STAT_OFS 8'h06
`define HIA_DMA_CMD_OFS 8'h40
`define HIA_DMA_STAT_OFS 8'h54
`define HIA_SCSI_ISR_OFS 8'h14

`define HIA_PCMD_PERR_RESP 6
`define HIA_PSTAT_DET_PERR 15
`define HIA_PSTAT_DPERR 8
`define HIA_DCMD_INTEN 6
`define HIA_DSTAT_PERR 1
`define HIA_DSTAT_ADDR_ERR 2
`define HIA_DSTAT_POWER_DOWN_PIN 3
`define HIA_DSTAT_SCSI 4
`define HIA_DSTAT_DONE 5

`define HIA_PCI_CMD_RST 16'h0000
`define HIA_DMA_CMD_RST 32'h0000_0000

`endif

/* File: inc/hia_pkg.sv */
// Types shared by the interrupt aggregator and its bench.
// Assumes nothing beyond the register header.
package hia_pkg;

  // Causes that the SCSI block can raise, one pulse each
  typedef struct packed {
    logic bus_reset;
    logic illegal_cmd;
    logic disconnect;
    logic service_req;
    logic cmd_done;
    logic reselected;
  } hia_scsi_ev_s;

  // Events from the DMA engine: done and address-error pulses, plus the bus-master level
  typedef struct packed {
    logic xfer_done;
    logic addr_err;
    logic bus_master;
  } hia_dma_ev_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } hia_req_s;

endpackage

/* File: design/hia_top.sv */
// Interrupt aggregator: gathers DMA and SCSI interrupt causes onto one
// active-low request and keeps the PCI parity error flags.
// Assumes a single-cycle register port from the PCI target and synchronous pins.
// A DMA status read clears only the DMA-source flags, never the SCSI one.
`timescale 1ns/100ps
`include "hia_regs.svh"

module hia_top
  import hia_pkg::*;
#(
  parameter int DATA_W = 32,              // Register bus width
  parameter int ADDR_W = 8,               // Register offset width
  parameter int PCI_W = 16,               // PCI command and status register width
  parameter int SCSI_N = 6,               // Number of SCSI block causes
  parameter int DFLAG_N = 4               // Number of DMA-source flags
)
(
  input wire logic clk_i,                 // 50 MHz clock
  input wire logic sys_rst_i,             // Synchronous reset, active high
  input wire hia_req_s req_i,             // Register access request
  output logic [31:0] rdata_o,            // Read data, one cycle after rd
  input wire hia_dma_ev_s dma_ev_i,       // DMA engine events
  input wire hia_scsi_ev_s scsi_ev_i,     // SCSI block causes
  input wire logic power_down_pin_i,      // Power-down pin, active high
  input wire logic parity_err_n_i,        // Parity error pin, active low
  output logic irq_n_o                    // Interrupt request, active low
);

  // The register map and the event structs are fixed; other sizes cannot be served
  if (DATA_W != 32 || ADDR_W != 8 || PCI_W != 16) begin : g_bad_bus
    $error("hia_top: bus widths must be 32, 8 and 16");
  end
  if (SCSI_N != $bits(hia_scsi_ev_s)) begin : g_bad_scsi
    $error("hia_top: SCSI cause count must match the event struct");
  end
  if (DFLAG_N != 4) begin : g_bad_flags
    $error("hia_top: exactly four DMA-source flags are kept");
  end
  // Two registers on one offset would leave the read mux ambiguous
  if (`HIA_PCI_CMD_OFS == `HIA_PCI_STAT_OFS || `HIA_PCI_CMD_OFS == `HIA_DMA_CMD_OFS
      || `HIA_PCI_CMD_OFS == `HIA_DMA_STAT_OFS || `HIA_PCI_CMD_OFS == `HIA_SCSI_ISR_OFS
      || `HIA_PCI_STAT_OFS == `HIA_DMA_CMD_OFS || `HIA_PCI_STAT_OFS == `HIA_DMA_STAT_OFS
      || `HIA_PCI_STAT_OFS == `HIA_SCSI_ISR_OFS || `HIA_DMA_CMD_OFS == `HIA_DMA_STAT_OFS
      || `HIA_DMA_CMD_OFS == `HIA_SCSI_ISR_OFS
      || `HIA_DMA_STAT_OFS == `HIA_SCSI_ISR_OFS) begin : g_bad_map
    $error("hia_top: two registers share an offset");
  end
  // Field positions must fall inside their registers
  if (`HIA_PSTAT_DET_PERR >= PCI_W || `HIA_PSTAT_DPERR >= PCI_W
      || `HIA_PCMD_PERR_RESP >= PCI_W) begin : g_bad_pci_bits
    $error("hia_top: PCI field outside its register");
  end
  if (`HIA_DSTAT_DONE >= DATA_W || `HIA_DCMD_INTEN >= DATA_W) begin : g_bad_dma_bits
    $error("hia_top: DMA field outside its register");
  end

  // Slots in dflag_r
  localparam int FL_PERR = 0;
  localparam int FL_ADDR = 1;
  localparam int FL_POWER_DOWN_PIN = 2;
  localparam int FL_DONE = 3;
  // Slots in pstat_r
  localparam int PS_DPERR = 0;
  localparam int PS_DET = 1;

  // Offset match, shared by the strobes and the read mux
  function automatic logic ofs_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] ofs);
    return addr == ofs;
  endfunction

  // Sticky flag update; a set meeting a clear in one cycle wins, so no event is lost
  function automatic logic flag_next(input logic set, input logic clr, input logic cur);
    return set || (cur && !clr);
  endfunction

  // Registered state
  logic [PCI_W-1:0] pci_cmd_r;
  logic [DATA_W-1:0] dma_cmd_r;
  logic [DFLAG_N-1:0] dflag_r;
  logic [1:0] pstat_r;
  logic scsi_pend_r;
  logic [SCSI_N-1:0] scsi_cause_r;
  logic power_down_pin_d_r;
  logic [DATA_W-1:0] rdata_r;
  logic irq_n_r;
  logic [DATA_W-1:0] dma_stat;
  logic [PCI_W-1:0] pci_stat;

  // Register select
  wire sel_pci_cmd = ofs_hit(req_i.addr, `HIA_PCI_CMD_OFS);
  wire sel_pci_stat = ofs_hit(req_i.addr, `HIA_PCI_STAT_OFS);
  wire sel_dma_cmd = ofs_hit(req_i.addr, `HIA_DMA_CMD_OFS);
  wire sel_dma_stat = ofs_hit(req_i.addr, `HIA_DMA_STAT_OFS);
  wire sel_scsi_isr = ofs_hit(req_i.addr, `HIA_SCSI_ISR_OFS);

  // Strobes last one cycle; write and read never come together
  wire wr_pci_cmd = req_i.wr && sel_pci_cmd;
  wire wr_pci_stat = req_i.wr && sel_pci_stat;
  wire wr_dma_cmd = req_i.wr && sel_dma_cmd;
  wire rd_dma_stat = req_i.rd && sel_dma_stat;
  wire rd_scsi_isr = req_i.rd && sel_scsi_isr;

  // Control bits and pins
  wire int_en = dma_cmd_r[`HIA_DCMD_INTEN];
  wire perr_resp = pci_cmd_r[`HIA_PCMD_PERR_RESP];
  wire perr_pin = !parity_err_n_i;
  wire is_master = dma_ev_i.bus_master;
  wire [SCSI_N-1:0] scsi_ev_vec = scsi_ev_i;

  // Event decode
  wire scsi_any = |scsi_ev_vec;
  // Parity is judged only while this device masters the bus for DMA
  wire perr_hit = perr_resp && perr_pin && is_master;
  wire power_down_pin_rise = power_down_pin_i && !power_down_pin_d_r;

  // Done and address events with the enable clear are dropped, not held back
  wire [DFLAG_N-1:0] dflag_set;
  assign dflag_set[FL_PERR] = perr_hit;
  assign dflag_set[FL_ADDR] = dma_ev_i.addr_err && int_en;
  assign dflag_set[FL_POWER_DOWN_PIN] = power_down_pin_rise;
  assign dflag_set[FL_DONE] = dma_ev_i.xfer_done && int_en;

  // Write-one-to-clear for the two PCI status error bits
  wire [1:0] pstat_clr;
  assign pstat_clr[PS_DET] = wr_pci_stat && req_i.wdata[`HIA_PSTAT_DET_PERR];
  assign pstat_clr[PS_DPERR] = wr_pci_stat && req_i.wdata[`HIA_PSTAT_DPERR];

  // Flags share one update rule, so one loop builds them all
  wire [DFLAG_N-1:0] dflag_nxt;
  genvar gi;
  for (gi = 0; gi < DFLAG_N; gi++) begin : g_dflag
    assign dflag_nxt[gi] = flag_next(dflag_set[gi], rd_dma_stat, dflag_r[gi]);
  end

  // Each PCI status bit is set by the parity hit and cleared by its own written one
  wire [1:0] pstat_nxt;
  for (gi = 0; gi < 2; gi++) begin : g_pstat
    assign pstat_nxt[gi] = flag_next(perr_hit, pstat_clr[gi], pstat_r[gi]);
  end

  // Cause bits collect until the SCSI status read takes them
  wire [SCSI_N-1:0] scsi_cause_nxt;
  for (gi = 0; gi < SCSI_N; gi++) begin : g_scause
    assign scsi_cause_nxt[gi] = flag_next(scsi_ev_vec[gi], rd_scsi_isr, scsi_cause_r[gi]);
  end

  // DMA status reads leave the SCSI flag alone; only the SCSI status read clears it
  wire scsi_pend_nxt = flag_next(scsi_any, rd_scsi_isr, scsi_pend_r);

  wire [PCI_W-1:0] pci_cmd_nxt = wr_pci_cmd ? req_i.wdata[PCI_W-1:0] : pci_cmd_r;
  wire [DATA_W-1:0] dma_cmd_nxt = wr_dma_cmd ? req_i.wdata : dma_cmd_r;

  // Raw flags; the parity one still needs the enable to reach the request
  wire st_perr = dflag_r[FL_PERR];
  wire st_addr = dflag_r[FL_ADDR];
  wire st_power_down_pin = dflag_r[FL_POWER_DOWN_PIN];
  wire st_done = dflag_r[FL_DONE];

  // Status words as the host sees them
  always_comb begin
    dma_stat = '0;
    dma_stat[`HIA_DSTAT_PERR] = st_perr;
    dma_stat[`HIA_DSTAT_ADDR_ERR] = st_addr;
    dma_stat[`HIA_DSTAT_POWER_DOWN_PIN] = st_power_down_pin;
    dma_stat[`HIA_DSTAT_SCSI] = scsi_pend_r;
    dma_stat[`HIA_DSTAT_DONE] = st_done;
  end

  always_comb begin
    pci_stat = '0;
    pci_stat[`HIA_PSTAT_DET_PERR] = pstat_r[PS_DET];
    pci_stat[`HIA_PSTAT_DPERR] = pstat_r[PS_DPERR];
  end

  // Read mux; unmapped offsets read as zero
  wire [DATA_W-1:0] pci_cmd_word = {{(DATA_W-PCI_W){1'b0}}, pci_cmd_r};
  wire [DATA_W-1:0] pci_stat_word = {{(DATA_W-PCI_W){1'b0}}, pci_stat};
  wire [DATA_W-1:0] scsi_isr_word = {{(DATA_W-SCSI_N){1'b0}}, scsi_cause_r};
  wire [DATA_W-1:0] rd_mux =
    sel_pci_cmd ? pci_cmd_word :
    sel_pci_stat ? pci_stat_word :
    sel_dma_cmd ? dma_cmd_r :
    sel_dma_stat ? dma_stat :
    sel_scsi_isr ? scsi_isr_word : '0;
  // Zero outside read cycles, so a stale word never lingers on the port
  wire [DATA_W-1:0] rdata_nxt = req_i.rd ? rd_mux : '0;

  // Done and address flags already passed their enable when they were set
  wire pend_xfer = st_done || st_addr;
  wire pend_power_down_pin = st_power_down_pin;
  // Parity flags count toward the request only with the enable; they still show in status
  wire pend_perr = st_perr && int_en;
  wire dma_pend = pend_xfer || pend_power_down_pin || pend_perr;
  wire any_pend = dma_pend || scsi_pend_r;
  wire irq_n_nxt = !any_pend;

  // PCI command register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pci_cmd_r <= `HIA_PCI_CMD_RST;
    end else begin
      pci_cmd_r <= pci_cmd_nxt;
    end
  end

  // DMA command register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      dma_cmd_r <= `HIA_DMA_CMD_RST;
    end else begin
      dma_cmd_r <= dma_cmd_nxt;
    end
  end

  // DMA-source flags
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      dflag_r <= '0;
    end else begin
      dflag_r <= dflag_nxt;
    end
  end

  // PCI status error bits
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pstat_r <= 2'b00;
    end else begin
      pstat_r <= pstat_nxt;
    end
  end

  // SCSI pending flag
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      scsi_pend_r <= 1'b0;
    end else begin
      scsi_pend_r <= scsi_pend_nxt;
    end
  end

  // SCSI cause bits
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      scsi_cause_r <= '0;
    end else begin
      scsi_cause_r <= scsi_cause_nxt;
    end
  end

  // Pin history for the first-assertion edge
  // Reset clears it, so a pin already high at release counts as a first assertion
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      power_down_pin_d_r <= 1'b0;
    end else begin
      power_down_pin_d_r <= power_down_pin_i;
    end
  end

  // Read data, valid the cycle after the read strobe
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Request pin; registered so it never glitches while flags change
  // It costs one cycle of latency after a flag sets or clears
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_n_r <= 1'b1;
    end else begin
      irq_n_r <= irq_n_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign irq_n_o = irq_n_r;

endmodule // hia_top

/* File: test/hia_props.sv */
// Port checker for the interrupt aggregator.
// Bound into hia_top; sees its ports only.
`timescale 1ns/100ps
module hia_props
  import hia_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic sys_rst_i, // Reset
  input wire hia_req_s req_i, // Request
  input wire logic [31:0] rdata_o, // Data
  input wire hia_dma_ev_s dma_ev_i, // DMA
  input wire hia_scsi_ev_s scsi_ev_i, // SCSI
  input wire logic power_down_pin_i, // Pin
  input wire logic parity_err_n_i, // Pin
  input wire logic irq_n_o // Irq
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic en_r, pr_r, sp_r;
  wire quiet = !(|scsi_ev_i) && !dma_ev_i.xfer_done && !dma_ev_i.addr_err && !power_down_pin_i;
  wire rd54 = req_i.rd && req_i.addr == 8'h54;
  // Shadows rebuilt from port traffic, since the registers are hidden
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      en_r <= 1'h0;
      pr_r <= 1'h0;
      sp_r <= 1'h0;
    end else begin
      if (req_i.wr && req_i.addr == 8'h40) en_r <= req_i.wdata[6];
      if (req_i.wr && req_i.addr == 8'h04) pr_r <= req_i.wdata[6];
      sp_r <= (|scsi_ev_i) || (sp_r && !(req_i.rd && req_i.addr == 8'h14));
    end
  end
  dma_irq_a: assert property ((dma_ev_i.xfer_done || dma_ev_i.addr_err) && en_r
    |=> ##1 !irq_n_o) else $error("dma cause without irq");
  power_down_pin_irq_a: assert property ($rose(power_down_pin_i) && !$past(sys_rst_i)
    |=> ##1 !irq_n_o) else $error("power down without irq");
  scsi_irq_a: assert property (|scsi_ev_i |=> ##1 !irq_n_o)
    else $error("scsi cause without irq");
  scsi_hold_a: assert property (sp_r |=> !irq_n_o) else $error("scsi irq dropped");
  perr_irq_a: assert property (pr_r && en_r && !parity_err_n_i && dma_ev_i.bus_master
    |=> ##1 !irq_n_o) else $error("parity error without irq");
  perr_mask_a: assert property (pr_r && !en_r && $past(!en_r) && !parity_err_n_i
    && irq_n_o && quiet && $past(quiet) && !sp_r |=> irq_n_o) else $error("masked parity irq");
  idle_rel_a: assert property (rd54 && quiet && parity_err_n_i && !sp_r
    |=> ##1 irq_n_o) else $error("irq held after status read");
  scsi_flag_a: assert property (rd54 && sp_r |=> rdata_o[4])
    else $error("scsi flag missing");
endmodule // hia_props
bind hia_top hia_props i_hia_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
  .rdata_o(rdata_o), .dma_ev_i(dma_ev_i), .scsi_ev_i(scsi_ev_i),
  .power_down_pin_i(power_down_pin_i), .parity_err_n_i(parity_err_n_i), .irq_n_o(irq_n_o));

/* File: test/hia_host.sv */
// Host driver model: register cycles and interrupt service.
// Drives on the falling edge; read data comes one cycle later.
`timescale 1ns/100ps
module hia_host
  import hia_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic [31:0] rdata_i, // Read data
  output hia_req_s req_o // Request
);
  initial req_o = '0;
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(negedge clk_i) req_o <= '{1'h1, 1'h0, a, v};
    @(negedge clk_i) req_o <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(negedge clk_i) req_o <= '{1'h0, 1'h1, a, 32'h0};
    @(negedge clk_i) v = rdata_i;
    req_o <= '0;
  endtask
  task automatic service(output logic [31:0] ds, output logic [31:0] si);
    rd(8'h54, ds);
    si = 32'h0;
    if (ds[4]) rd(8'h14, si);
  endtask
endmodule // hia_host

/* File: test/hia_top_tb.sv */
// Self-checking bench for the interrupt aggregator.
// Registers are reached through the host model.
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
  $display("unexpected %s exp %0h got %0h", n, e, a); end end
module hia_top_tb;
  import hia_pkg::*;
  logic clk_i = 1'h0, sys_rst_i = 1'h1, pwr = 1'h0, perr_n = 1'h1, irq_n;
  hia_dma_ev_s dma = '0;
  hia_scsi_ev_s sev = '0;
  hia_req_s req;
  logic [31:0] rdata, d, si;
  int fail_count = 0, n_tests = 0;
  always #10 clk_i = ~clk_i;
  hia_top i_hia_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req), .rdata_o(rdata),
    .dma_ev_i(dma), .scsi_ev_i(sev), .power_down_pin_i(pwr), .parity_err_n_i(perr_n),
    .irq_n_o(irq_n));
  hia_host i_hia_host (.clk_i(clk_i), .rdata_i(rdata), .req_o(req));
  task automatic w(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic t_dma;
    for (int e = 0; e < 2; e++) begin
      i_hia_host.wr(8'h40, e << 6);
      dma = '{1'h1, 1'h1, 1'h0};
      w(1);
      dma = '0;
      w(2);
      `CHK("irq_dma", e == 0, irq_n)
      i_hia_host.rd(8'h54, d);
      w(2);
      `CHK("dstat", {e == 1, 2'h0, e == 1}, d[5:2])
      `CHK("irq_rel", 1'h1, irq_n)
      i_hia_host.rd(8'h54, d);
      `CHK("dstat_clr", 32'h0, d)
    end
    $display("t_dma finished");
  endtask
  task automatic t_scsi;
    for (int i = 0; i < 6; i++) begin
      sev = 6'h1 << i;
      w(1);
      sev = '0;
      w(2);
      `CHK("irq_scsi", 1'h0, irq_n)
      i_hia_host.rd(8'h54, d);
      w(2);
      `CHK("dstat_b4", 1'h1, d[4])
      `CHK("irq_hold", 1'h0, irq_n)
      i_hia_host.rd(8'h14, d);
      w(2);
      `CHK("isr", 32'h1 << i, d)
      `CHK("irq_clr", 1'h1, irq_n)
    end
    $display("t_scsi finished");
  endtask
  task automatic t_power_down_pin;
    pwr = 1'h1;
    w(3);
    `CHK("irq_power_down_pin", 1'h0, irq_n)
    i_hia_host.service(d, si);
    w(4);
    `CHK("dstat_b3", 32'h8, d)
    `CHK("irq_once", 1'h1, irq_n)
    pwr = 1'h0;
    $display("t_power_down_pin finished");
  endtask
  task automatic t_perr;
    i_hia_host.wr(8'h04, 32'h40);
    for (int m = 0; m < 3; m++) begin
      i_hia_host.wr(8'h40, m == 2 ? 32'h40 : 32'h0);
      dma.bus_master = m[0] | m[1];
      perr_n = 1'h0;
      w(1);
      perr_n = 1'h1;
      w(2);
      `CHK("irq_perr", m != 2, irq_n)
      dma.bus_master = 1'h0;
      i_hia_host.rd(8'h54, d);
      `CHK("dstat_b1", {30'h0, m != 0, 1'h0}, d)
      i_hia_host.rd(8'h06, d);
      `CHK("pstat", m != 0 ? 32'h8100 : 32'h0, d)
      i_hia_host.wr(8'h06, 32'h8100);
    end
    i_hia_host.rd(8'h20, d);
    `CHK("unmapped", 32'h0, d)
    $display("t_perr finished");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    w(12);
    sys_rst_i = 1'h0;
    `CHK("irq_rst", 1'h1, irq_n)
    t_dma();
    t_scsi();
    t_power_down_pin();
    t_perr();
    wrap_up();
  end
  // Tests need well under 400 cycles; five times that marks a hang
  initial begin
    repeat (2000) @(posedge clk_i);
    fail_count++;
    wrap_up();
  end
endmodule // hia_top_tb
